// >>> include/rswc_defines.vh
/*
 sleep/wake controller constants: register offsets, field positions,
 reset values and timing counts. assumes a 25 MHz mclk.
*/
`ifndef RSWC_DEFINES_VH
`define RSWC_DEFINES_VH

`define RSWC_CLK_HZ          25000000
`define RSWC_MS_CYCLES       (`RSWC_CLK_HZ / 1000)
`define RSWC_MS_CNT_W        15
`define RSWC_MS_LAST         15'h61A7
`define RSWC_INTERVAL_W      13
`define RSWC_INTERVAL_MIN    13'h0064
`define RSWC_INTERVAL_MAX    13'h1388
`define RSWC_INTERVAL_RESET  13'h0000
`define RSWC_CAD_WINDOW_MS   13'h0005
`define RSWC_FIFO_W          8
`define RSWC_FIFO_D          16

`define RSWC_OFF_CTRL        8'h00
`define RSWC_OFF_INTERVAL    8'h04
`define RSWC_OFF_CHANNEL     8'h08
`define RSWC_OFF_RATE        8'h0C
`define RSWC_OFF_ENC         8'h10
`define RSWC_OFF_KEY         8'h14
`define RSWC_OFF_STATUS      8'h18
`define RSWC_OFF_RXDATA      8'h1C

`define RSWC_CTRL_CMD_EN     0
`define RSWC_ST_STATE_LSB    0
`define RSWC_ST_VALID        8
`define RSWC_ST_BADINT       9
`define RSWC_ST_SERIAL_OK    10

`endif

// >>> hw/rswc_fifo.v
/*
 rswc_fifo: synchronous fifo with valid/ready on both sides.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module rswc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // compared, not sliced: the depth parameter is an unranged integer
  assign in_ready  = (count < DEPTH);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  always @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// >>> hw/rswc_top.v
/*
 rswc_top: sleep and wake-on-radio controller for a serial radio node.
 holds the interval/channel/rate/encryption settings behind an AHB-Lite
 slave, runs the sleep sequencer from the two mode pins and buffers
 received radio bytes in a fifo that software drains over the bus.
 assumes one 25 MHz clock, synchronous active-high reset, async pins.
*/
// The register addresses and register access over AHB-Lite were decided locally.
// Notes on behaviour
// - set/query interval, channel, rate, encryption, key
// - wake each interval, check activity, resleep
// - on activity take packet, forward, sleep
// - no serial commands in wor; pins high wake
// - interval zero means pure sleep until pin
// - pure sleep ignores serial commands
`timescale 1ns/1ps
`include "rswc_defines.vh"
module rswc_top (
  input  wire        mclk,
  input  wire        rst,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hsel,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        mode_select_a,
  input  wire        mode_select_b,
  input  wire        channel_activity_detect,
  input  wire [7:0]  radio_rx_data,
  input  wire        radio_rx_valid,
  output wire        radio_rx_ready,
  input  wire        radio_rx_last,
  output reg         radio_on,
  output reg         low_power,
  output reg         serial_ok
);
  localparam [4:0] ST_ACTIVE  = 5'h01;
  localparam [4:0] ST_SLEEP   = 5'h02;
  localparam [4:0] ST_LISTEN  = 5'h04;
  localparam [4:0] ST_RECEIVE = 5'h08;
  localparam [4:0] ST_PURE    = 5'h10;
  localparam [`RSWC_MS_CNT_W-1:0] MS_LAST =
    `RSWC_MS_LAST;

  // two-flop synchronisers for the asynchronous pins
  reg  [2:0] sync1;
  reg  [2:0] sync2;
  wire       pin_a;
  wire       pin_b;
  wire       cad;
  always @(posedge mclk) begin
    if (rst) begin
      // pins read high and activity low, so release shows no false entry
      sync1 <= 3'h3;
      sync2 <= 3'h3;
    end else begin
      sync1 <= {channel_activity_detect, mode_select_b, mode_select_a};
      sync2 <= sync1;
    end
  end
  assign pin_a = sync2[0];
  assign pin_b = sync2[1];
  assign cad   = sync2[2];

  wire pins_low  = ~pin_a & ~pin_b;
  wire pins_high = pin_a & pin_b;

  // settings registers
  reg [`RSWC_INTERVAL_W-1:0] wake_interval_ms;
  reg [7:0]                  channel;
  reg [7:0]                  rate;
  reg                        enc_on;
  reg [31:0]                 enc_key;
  reg                        cmd_en;
  reg                        bad_interval;

  reg [4:0] state;
  reg [4:0] next_state;

  // ahb-lite address phase capture
  reg        dp_valid;
  reg        dp_write;
  reg [7:0]  dp_addr;
  wire       ap_take = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge mclk) begin
    if (rst) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (hready) begin
      dp_valid <= ap_take;
      dp_write <= hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  // settings only change while serial commands are accepted
  wire wr_ok = dp_valid & dp_write & serial_ok;

  always @(posedge mclk) begin
    if (rst) begin
      wake_interval_ms <= `RSWC_INTERVAL_RESET;
      channel          <= 8'h00;
      rate             <= 8'h00;
      enc_on           <= 1'b0;
      enc_key          <= 32'h00000000;
      cmd_en           <= 1'b1;
      bad_interval     <= 1'b0;
    end else if (wr_ok) begin
      case (dp_addr)
        `RSWC_OFF_CTRL:     cmd_en <= hwdata[`RSWC_CTRL_CMD_EN];
        `RSWC_OFF_INTERVAL: begin
          wake_interval_ms <= hwdata[`RSWC_INTERVAL_W-1:0];
          // flags a value outside 0 or 100..5000; still stored
          bad_interval <= (hwdata[31:`RSWC_INTERVAL_W] != 19'h00000) |
            ((hwdata[`RSWC_INTERVAL_W-1:0] != 13'h0000) &
             ((hwdata[`RSWC_INTERVAL_W-1:0] < `RSWC_INTERVAL_MIN) |
              (hwdata[`RSWC_INTERVAL_W-1:0] > `RSWC_INTERVAL_MAX)));
        end
        `RSWC_OFF_CHANNEL:  channel <= hwdata[7:0];
        `RSWC_OFF_RATE:     rate    <= hwdata[7:0];
        `RSWC_OFF_ENC:      enc_on  <= hwdata[0];
        `RSWC_OFF_KEY:      enc_key <= hwdata;
        default:            cmd_en  <= cmd_en;
      endcase
    end
  end

  // fifo between radio receiver and the bus
  wire [7:0] fifo_data;
  wire       fifo_valid;
  wire       fifo_pop;
  wire       fifo_in_ready;
  wire       rx_take = (state == ST_RECEIVE);

  rswc_fifo #(
    .WIDTH (`RSWC_FIFO_W),
    .DEPTH (`RSWC_FIFO_D),
    .AW    (4)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (radio_rx_data),
    .in_valid  (radio_rx_valid & rx_take),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  // receiver stalls when the fifo fills; it only accepts while receiving
  assign radio_rx_ready = fifo_in_ready & rx_take;

  // read decode happens at the address phase so data lands at the edge
  wire rd_take = ap_take & ~hwrite;
  assign fifo_pop = rd_take & (haddr[7:0] == `RSWC_OFF_RXDATA) &
                    fifo_valid;

  always @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      case (haddr[7:0])
        `RSWC_OFF_CTRL:     hrdata <= {31'h00000000, cmd_en};
        `RSWC_OFF_INTERVAL: hrdata <= {19'h00000, wake_interval_ms};
        `RSWC_OFF_CHANNEL:  hrdata <= {24'h000000, channel};
        `RSWC_OFF_RATE:     hrdata <= {24'h000000, rate};
        `RSWC_OFF_ENC:      hrdata <= {31'h00000000, enc_on};
        `RSWC_OFF_KEY:      hrdata <= enc_key;
        `RSWC_OFF_STATUS:   hrdata <= {21'h000000, serial_ok,
                                       bad_interval, fifo_valid,
                                       3'h0, state};
        // an empty fifo reads as zero rather than a stale byte
        `RSWC_OFF_RXDATA:   hrdata <= {23'h000000, fifo_valid,
                                       fifo_data & {8{fifo_valid}}};
        default:            hrdata <= 32'h00000000;
      endcase
    end
  end

  // millisecond tick and interval counter
  reg [`RSWC_MS_CNT_W-1:0]   ms_cnt;
  reg [`RSWC_INTERVAL_W-1:0] elapsed;
  wire ms_tick = (ms_cnt == MS_LAST);
  wire in_sleep = (state == ST_SLEEP);
  wire in_listen = (state == ST_LISTEN);

  always @(posedge mclk) begin
    if (rst || !(in_sleep || in_listen)) begin
      ms_cnt <= {`RSWC_MS_CNT_W{1'b0}};
    end else if (ms_tick) begin
      ms_cnt <= {`RSWC_MS_CNT_W{1'b0}};
    end else begin
      ms_cnt <= ms_cnt + 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (rst || next_state != state) begin
      elapsed <= {`RSWC_INTERVAL_W{1'b0}};
    end else if (ms_tick) begin
      elapsed <= elapsed + 1'b1;
    end
  end

  wire interval_done = ms_tick &
    (elapsed == wake_interval_ms - 1'b1);
  wire listen_done = ms_tick &
    (elapsed == `RSWC_CAD_WINDOW_MS - 1'b1);
  wire enter_low = pins_low & cmd_en;

  always @* begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (enter_low) begin
          if (wake_interval_ms == 13'h0000) begin
            next_state = ST_PURE;
          end else begin
            next_state = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (pins_high) begin
          next_state = ST_ACTIVE;
        end else if (interval_done) begin
          next_state = ST_LISTEN;
        end
      end
      ST_LISTEN: begin
        if (pins_high) begin
          next_state = ST_ACTIVE;
        end else if (cad) begin
          next_state = ST_RECEIVE;
        end else if (listen_done) begin
          next_state = ST_SLEEP;
        end
      end
      ST_RECEIVE: begin
        // the packet finishes before the pins are honoured
        if (radio_rx_valid & radio_rx_ready & radio_rx_last) begin
          next_state = pins_high ? ST_ACTIVE : ST_SLEEP;
        end
      end
      ST_PURE: begin
        if (pins_high) begin
          next_state = ST_ACTIVE;
        end
      end
      default: next_state = ST_ACTIVE;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state     <= ST_ACTIVE;
      radio_on  <= 1'b1;
      low_power <= 1'b0;
      serial_ok <= 1'b1;
    end else begin
      state     <= next_state;
      radio_on  <= (next_state != ST_SLEEP) & (next_state != ST_PURE);
      low_power <= (next_state == ST_SLEEP) | (next_state == ST_PURE);
      serial_ok <= (next_state == ST_ACTIVE);
    end
  end
endmodule

// >>> testbench/rswc_chk.sv
/*
 rswc_chk: port-level assertions for rswc_top.
 assumes one mclk domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module rswc_chk (
  input wire mclk,
  input wire rst,
  input wire hreadyout,
  input wire hresp,
  input wire mode_select_a,
  input wire mode_select_b,
  input wire radio_rx_ready,
  input wire radio_on,
  input wire low_power,
  input wire serial_ok
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence pins_high; mode_select_a && mode_select_b; endsequence
  sequence asleep; low_power; endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  sleep_quiet_a: assert property (asleep |-> !radio_on && !serial_ok)
    else $error("radio or serial alive in sleep");
  enter_pins_a: assert property ($fell(serial_ok) |->
    !mode_select_a && !mode_select_b)
    else $error("serial closed without both pins low");
  wake_pins_a: assert property (asleep ##0 pins_high |->
    ##[1:8] serial_ok)
    else $error("pins high did not wake");
  stay_mute_a: assert property (!serial_ok && !mode_select_a &&
    !mode_select_b |=> !serial_ok)
    else $error("serial reopened with pins low");
  listen_on_a: assert property ($fell(low_power) |-> radio_on)
    else $error("wake without radio on");
  rx_gate_a: assert property (radio_rx_ready |->
    radio_on && !low_power && !serial_ok)
    else $error("radio accepted outside receive");
endmodule
bind rswc_top rswc_chk u_chk (.mclk(mclk), .rst(rst),
  .hreadyout(hreadyout), .hresp(hresp), .mode_select_a(mode_select_a),
  .mode_select_b(mode_select_b), .radio_rx_ready(radio_rx_ready),
  .radio_on(radio_on), .low_power(low_power), .serial_ok(serial_ok));

// >>> testbench/rswc_host_model.sv
/*
 rswc_host_model: host side of the mode pins.
 assumes the bench asks for low power through want_low.
*/
`timescale 1ns/1ps
module rswc_host_model (
  input  wire mclk,
  input  wire rst,
  input  wire want_low,
  output reg  mode_select_a,
  output reg  mode_select_b
);
  // both pins move on one edge so mixed levels never show
  initial begin
    mode_select_a = 1'b1;
    mode_select_b = 1'b1;
  end
  always @(posedge mclk) begin
    mode_select_a <= rst ? 1'b1 : !want_low;
    mode_select_b <= rst ? 1'b1 : !want_low;
  end
endmodule

// >>> testbench/radio_sleep_wake_control_tb_top.sv
/*
 bench for rswc_top: bus tasks, pure sleep, timed sleep and receive.
 assumes 25 MHz mclk and a 16-byte receive fifo.
*/
`timescale 1ns/1ps
module radio_sleep_wake_control_tb_top;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         want_low = 1'b0;
  reg         cad = 1'b0;
  reg  [7:0]  rx_data = 8'h00;
  reg         rx_valid = 1'b0;
  reg         rx_last = 1'b0;
  wire        hreadyout, hresp, rx_ready, msa, msb, radio_on, lp, ser;
  wire [31:0] hrdata;
  wire [3:0]  outs = {rx_ready, radio_on, lp, ser};
  integer     fail_count = 0;
  integer     checked = 0;
  integer     i, n;
  reg  [31:0] rd;
  always #20 mclk = ~mclk;
  rswc_host_model host (.mclk(mclk), .rst(rst), .want_low(want_low),
    .mode_select_a(msa), .mode_select_b(msb));
  rswc_top uut (.mclk(mclk), .rst(rst), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mode_select_a(msa), .mode_select_b(msb),
    .channel_activity_detect(cad), .radio_rx_data(rx_data),
    .radio_rx_valid(rx_valid), .radio_rx_ready(rx_ready),
    .radio_rx_last(rx_last), .radio_on(radio_on), .low_power(lp),
    .serial_ok(ser));
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  task rdc(input string what, input [31:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(what, e, rd);
      chk("hresp", 0, hresp);
    end
  endtask
  // bounded wait for one of the outputs to go high
  task wait_hi(input integer s, input integer lim);
    begin
      n = 0;
      while (outs[s] !== 1'b1 && n < lim) begin
        @(posedge mclk);
        n = n + 1;
      end
      chk("wait", 1, outs[s]);
    end
  endtask
  // holds valid until taken; the caller releases after the last byte
  task send(input [7:0] b, input l);
    begin
      rx_valid <= 1'b1;
      rx_data <= b;
      rx_last <= l;
      do @(posedge mclk); while (rx_ready !== 1'b1);
    end
  endtask
  initial begin
    #(40 * 80000);
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    @(posedge mclk);
    chk("outs", 32'h3, {lp, radio_on, ser});
    rdc("ctrl", 32'h0, 32'h1);
    rdc("status", 32'h18, 32'h401);
    for (i = 1; i < 6; i = i + 1) begin
      bus(1'b1, i * 4, 32'hFFFFFFFF);
      rdc("reg", i * 4, i == 1 ? 32'h1FFF : i == 4 ? 32'h1 :
        i == 5 ? 32'hFFFFFFFF : 32'hFF);
    end
    rdc("bad_int", 32'h18, 32'h601);
    rdc("unmapped", 32'h20, 32'h0);
    // with cmd_en cleared, pins low must leave the node awake
    bus(1'b1, 32'h0, 32'h0);
    want_low <= 1'b1;
    repeat (8) @(posedge mclk);
    rdc("blocked", 32'h18, 32'h601);
    want_low <= 1'b0;
    repeat (4) @(posedge mclk);
    bus(1'b1, 32'h0, 32'h1);
    bus(1'b1, 32'h4, 32'h0);
    want_low <= 1'b1;
    wait_hi(1, 10);
    rdc("pure", 32'h18, 32'h10);
    bus(1'b1, 32'h8, 32'h55);
    want_low <= 1'b0;
    wait_hi(0, 10);
    rdc("chan", 32'h8, 32'hFF);
    // a 1 ms interval keeps the timed sleep short; it is flagged only
    bus(1'b1, 32'h4, 32'h1);
    want_low <= 1'b1;
    wait_hi(1, 10);
    wait_hi(2, 30000);
    chk("sleep_len", 1, n >= 24998 && n <= 25002);
    cad <= 1'b1;
    wait_hi(3, 10);
    for (i = 0; i < 16; i = i + 1)
      send(8'h30 + i[7:0], 1'b0);
    rx_valid <= 1'b0;
    cad <= 1'b0;
    @(posedge mclk);
    chk("full", 0, rx_ready);
    rdc("rx0", 32'h1C, 32'h130);
    send(8'hA5, 1'b1);
    rx_valid <= 1'b0;
    wait_hi(1, 10);
    for (i = 1; i < 16; i = i + 1)
      rdc("rx", 32'h1C, 32'h130 + i);
    rdc("rx_last", 32'h1C, 32'h1A5);
    rdc("rx_empty", 32'h1C, 32'h0);
    want_low <= 1'b0;
    wait_hi(0, 10);
    give_verdict;
  end
endmodule
